// File: include/gdl_map.svh
// Constants for the gate driver lockout and dead-time block.
// Assumes a 200 MHz clock_i; included by the gate driver design file only.
`ifndef GDL_MAP_SVH
`define GDL_MAP_SVH
// ==========================================================
// Timing
`define GDL_CLK_PERIOD_PS 5000
`define GDL_STARTUP_NS 5000
`define GDL_SHUTDOWN_NS 60
`define GDL_RESTART_NS 60
`define GDL_RECOVERY_NS 7000
`define GDL_DT_SHORT_MIN_NS 10
`define GDL_DT_SHORT_MAX_NS 200
`define GDL_DT_LONG_MIN_NS 20
`define GDL_DT_LONG_MAX_NS 700
`define GDL_CNT_W 12
// ==========================================================
// Register map
`define GDL_REG_CTRL 8'h00
`define GDL_REG_DEAD 8'h04
`define GDL_REG_STAT 8'h08
`define GDL_CTRL_MODE_LO 0
`define GDL_CTRL_MODE_HI 1
`define GDL_CTRL_DT_EN 2
`define GDL_CTRL_DT_LONG 3
`define GDL_CTRL_RESET 32'h0000_0000
`define GDL_DEAD_RESET 32'h0000_0004
`define GDL_RESP_OKAY 2'b00
`define GDL_RESP_SLVERR 2'b10
`endif

// File: include/gdl_pkg.sv
// Types shared by the gate driver lockout block.
// Assumes gdl_map.svh is on the include path.
package gdl_pkg;
	// Input mapping mode
	typedef enum logic [1:0] {
		gdl_mode_dual = 2'h0,
		gdl_mode_half = 2'h1,
		gdl_mode_pwm = 2'h2
	} gdl_mode_t;
	// Supply-good levels, raw from comparators
	typedef struct packed {
		logic in_above_rise;
		logic in_above_fall;
		logic a_above_rise;
		logic a_above_fall;
		logic b_above_rise;
		logic b_above_fall;
	} gdl_supply_t;
	// Controller-side logic inputs
	typedef struct packed {
		logic channel_a_input;
		logic channel_b_input;
		logic enable;
	} gdl_ctl_t;
endpackage

// File: rtl/gdl_lockout.sv
// Hysteresis lockout monitor for one supply.
// Assumes above_rise/above_fall already synchronised to clock_i.
`timescale 1ns/100ps
module gdl_lockout (
	input wire logic clock_i, // System clock
	input wire logic rst_i, // Async reset, active high
	input wire logic above_rise_i, // Supply above rising threshold
	input wire logic above_fall_i, // Supply above falling threshold
	output logic locked_o // In undervoltage lockout
);
	// ==========================================================
	// Lockout flag: leave above rising, enter below falling
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			locked_o <= 1'b1;
		end else if (!above_fall_i) begin
			locked_o <= 1'b1;
		end else if (above_rise_i) begin
			locked_o <= 1'b0;
		end
	end
endmodule

// File: rtl/gdl_driver.sv
// Control logic of a two-channel isolated gate driver.
// Assumes supply comparators and controller pins are asynchronous;
// software sets mode and dead time over AXI4-Lite.
`timescale 1ns/100ps
`include "gdl_map.svh"
module gdl_driver #(
	parameter int STARTUP_CYC = (`GDL_STARTUP_NS * 1000 + `GDL_CLK_PERIOD_PS - 1)
		/ `GDL_CLK_PERIOD_PS,
	parameter int DT_W = 8
) (
	input wire logic clock_i, // System clock, 200 MHz
	input wire logic rst_i, // Async reset, active high
	input wire gdl_pkg::gdl_supply_t supply_i, // Raw supply comparators
	input wire gdl_pkg::gdl_ctl_t ctl_i, // Raw controller pins
	output logic channel_a_output_o, // Driver output A
	output logic channel_b_output_o, // Driver output B
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready // Read data ready
);
	import gdl_pkg::*;

	// Delays become whole clock cycles; shutdown and restart never drop below one
	localparam int SD_CYC_RAW = (`GDL_SHUTDOWN_NS * 1000) / `GDL_CLK_PERIOD_PS;
	localparam int SD_CYC = (SD_CYC_RAW < 1) ? 1 : SD_CYC_RAW;
	localparam int RS_CYC_RAW = (`GDL_RESTART_NS * 1000) / `GDL_CLK_PERIOD_PS;
	localparam int RS_CYC = (RS_CYC_RAW < 1) ? 1 : RS_CYC_RAW;
	localparam int DTS_MIN = (`GDL_DT_SHORT_MIN_NS * 1000) / `GDL_CLK_PERIOD_PS;
	localparam int DTS_MAX = (`GDL_DT_SHORT_MAX_NS * 1000) / `GDL_CLK_PERIOD_PS;
	localparam int DTL_MIN = (`GDL_DT_LONG_MIN_NS * 1000) / `GDL_CLK_PERIOD_PS;
	localparam int DTL_MAX = (`GDL_DT_LONG_MAX_NS * 1000) / `GDL_CLK_PERIOD_PS;
	localparam int CW = `GDL_CNT_W;

	// ==========================================================
	// Elaboration checks
	// Refused at elaboration: counters too narrow for the delays they must hold
	if (STARTUP_CYC < 1 || STARTUP_CYC >= (1 << CW)) begin : g_bad_startup
		$error("STARTUP_CYC out of range");
	end
	if (RS_CYC >= (1 << CW) || SD_CYC >= (1 << CW)) begin : g_bad_enable
		$error("Enable delays too long for the counter");
	end
	// The dead-time register spans at most two byte lanes
	if (DT_W < 8 || DT_W > 16) begin : g_bad_dt_w
		$error("DT_W out of range");
	end
	if (DTL_MAX >= (1 << DT_W)) begin : g_bad_dt_range
		$error("Long dead-time range does not fit DT_W");
	end

	// ==========================================================
	// Synchronisers
	// Supplies and controller pins arrive from outside this clock
	logic [8:0] sync1;
	logic [8:0] sync2;
	// Two flops on every asynchronous input
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sync1 <= 9'h000;
			sync2 <= 9'h000;
		end else begin
			sync1 <= {supply_i, ctl_i};
			sync2 <= sync1;
		end
	end
	// Synchronised copies; only the second stage is ever read
	gdl_supply_t sup;
	gdl_ctl_t ctl;
	assign sup = sync2[8:3];
	assign ctl = sync2[2:0];

	// ==========================================================
	// Lockout monitors, one per supply
	logic lock_in;
	logic lock_a;
	logic lock_b;
	gdl_lockout u_lock_in (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.above_rise_i(sup.in_above_rise),
		.above_fall_i(sup.in_above_fall),
		.locked_o(lock_in)
	);
	gdl_lockout u_lock_a (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.above_rise_i(sup.a_above_rise),
		.above_fall_i(sup.a_above_fall),
		.locked_o(lock_a)
	);
	gdl_lockout u_lock_b (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.above_rise_i(sup.b_above_rise),
		.above_fall_i(sup.b_above_fall),
		.locked_o(lock_b)
	);

	// ==========================================================
	// Startup hold: all supplies good for the startup time
	logic any_lock;
	logic [CW-1:0] start_cnt;
	logic started;
	assign any_lock = lock_in | lock_a | lock_b;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			start_cnt <= '0;
			started <= 1'b0;
		end else if (lock_in) begin
			// Input-side lockout restarts the whole hold; once started, driver lockouts only their own pin
			start_cnt <= '0;
			started <= 1'b0;
		end else if (!started && any_lock) begin
			start_cnt <= '0;
		end else if (!started) begin
			if (start_cnt == CW'(STARTUP_CYC - 1)) begin
				started <= 1'b1;
			end
			start_cnt <= start_cnt + 1'b1;
		end
	end

	// ==========================================================
	// Enable gating with shutdown and restart delays
	// An enable glitch shorter than the delay never reaches the outputs
	logic [CW-1:0] en_cnt;
	logic en_act;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			en_cnt <= '0;
			en_act <= 1'b0;
		end else if (ctl.enable == en_act) begin
			en_cnt <= '0;
		end else if (en_act && en_cnt == CW'(SD_CYC - 1)) begin
			en_act <= 1'b0;
			en_cnt <= '0;
		end else if (!en_act && en_cnt == CW'(RS_CYC - 1)) begin
			en_act <= 1'b1;
			en_cnt <= '0;
		end else begin
			en_cnt <= en_cnt + 1'b1;
		end
	end

	// ==========================================================
	// Register file
	// Software settings, all cleared to their reset values
	logic [1:0] mode_r;
	logic dt_en;
	logic dt_long;
	logic [DT_W-1:0] dt_val;
	gdl_mode_t mode;
	assign mode = gdl_mode_t'(mode_r);

	// ==========================================================
	// Input mapping per mode
	// Mode 3 falls through to plain dual-input behaviour
	logic want_a;
	logic want_b;
	always_comb begin
		want_a = ctl.channel_a_input;
		want_b = ctl.channel_b_input;
		if (mode == gdl_mode_pwm) begin
			want_a = ctl.channel_a_input;
			want_b = ~ctl.channel_a_input;
		end else if (mode == gdl_mode_half && ctl.channel_a_input
				&& ctl.channel_b_input) begin
			want_a = 1'b0;
			want_b = 1'b0;
		end
		// A channel in lockout pulls its own pin low whatever the mode
		if (lock_a) want_a = 1'b0;
		if (lock_b) want_b = 1'b0;
	end

	// ==========================================================
	// Dead time: delay each rising edge while the other side settles
	// Out-of-range settings are clamped rather than refused
	logic [DT_W-1:0] dt_clamped;
	logic [DT_W-1:0] dt_cnt;
	logic a_q;
	logic b_q;
	logic use_dt;
	always_comb begin
		dt_clamped = dt_val;
		if (dt_long) begin
			if (dt_val < DT_W'(DTL_MIN)) dt_clamped = DT_W'(DTL_MIN);
			if (dt_val > DT_W'(DTL_MAX)) dt_clamped = DT_W'(DTL_MAX);
		end else begin
			if (dt_val < DT_W'(DTS_MIN)) dt_clamped = DT_W'(DTS_MIN);
			if (dt_val > DT_W'(DTS_MAX)) dt_clamped = DT_W'(DTS_MAX);
		end
	end
	// Dead time only applies in the single-input mode
	assign use_dt = dt_en && (mode == gdl_mode_pwm);
	// Outputs may drive only once started and while enable is active
	logic gate_ok;
	assign gate_ok = started && en_act;
	// Output registers; falling edges immediate, rising after dead time
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			dt_cnt <= '0;
		end else if (!gate_ok) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			dt_cnt <= '0;
		end else begin
			a_q <= a_q & want_a;
			b_q <= b_q & want_b;
			if (!use_dt) begin
				a_q <= want_a;
				b_q <= want_b;
				dt_cnt <= '0;
			end else if ((want_a && !a_q) || (want_b && !b_q)) begin
				// Wait for both pins low, then count the programmed cycles
				if (a_q || b_q) begin
					dt_cnt <= '0;
				end else if (dt_cnt >= dt_clamped - 1'b1) begin
					a_q <= want_a;
					b_q <= want_b;
					dt_cnt <= '0;
				end else begin
					dt_cnt <= dt_cnt + 1'b1;
				end
			end else begin
				dt_cnt <= '0;
			end
		end
	end
	// Outputs straight from the flops; channel lockout is folded into want_a/want_b
	assign channel_a_output_o = a_q;
	assign channel_b_output_o = b_q;

	// ==========================================================
	// AXI4-Lite write path
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	// No new address or data is taken while a response is still pending
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	// Capture address and data in either order, then apply
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `GDL_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			// Both halves in hand: answer and apply on the same edge
			if (aw_held && w_held) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr == `GDL_REG_CTRL || aw_addr == `GDL_REG_DEAD)
					s_axi_bresp <= `GDL_RESP_OKAY;
				else
					s_axi_bresp <= `GDL_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// Merge the strobed lanes into the dead-time value; works for any DT_W up to 16
	logic [15:0] dead_merged;
	always_comb begin
		dead_merged = 16'(dt_val);
		if (w_strb[0]) dead_merged[7:0] = w_data[7:0];
		if (w_strb[1]) dead_merged[15:8] = w_data[15:8];
	end
	// Register updates from the strobes captured with the data
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			mode_r <= 2'(`GDL_CTRL_RESET);
			dt_en <= 1'b0;
			dt_long <= 1'b0;
			dt_val <= DT_W'(`GDL_DEAD_RESET);
		end else if (aw_held && w_held) begin
			if (aw_addr == `GDL_REG_CTRL && w_strb[0]) begin
				mode_r <= w_data[`GDL_CTRL_MODE_HI:`GDL_CTRL_MODE_LO];
				dt_en <= w_data[`GDL_CTRL_DT_EN];
				dt_long <= w_data[`GDL_CTRL_DT_LONG];
			end else if (aw_addr == `GDL_REG_DEAD) begin
				dt_val <= dead_merged[DT_W-1:0];
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	// One read in flight: address ready drops while data waits
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `GDL_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `GDL_RESP_OKAY;
			if (s_axi_araddr == `GDL_REG_CTRL) begin
				s_axi_rdata <= {28'h0000000, dt_long, dt_en, mode_r};
			end else if (s_axi_araddr == `GDL_REG_DEAD) begin
				s_axi_rdata <= 32'(dt_val);
			end else if (s_axi_araddr == `GDL_REG_STAT) begin
				// Live status snapshot taken when the address is accepted
				s_axi_rdata <= {24'h000000, channel_b_output_o, channel_a_output_o,
					en_act, started, lock_b, lock_a, lock_in, ctl.enable};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `GDL_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// File: verif/gdl_driver_assertions.sv
// Checker for the gate driver block: lockout, enable and bus handshakes.
// Assumes it is bound to gdl_driver and sees only its ports.
`timescale 1ns/100ps
module gdl_driver_assertions (
	input wire logic clock_i, // Clock
	input wire logic rst_i, // Reset
	input wire gdl_pkg::gdl_supply_t supply_i, // Supply levels
	input wire gdl_pkg::gdl_ctl_t ctl_i, // Control pins
	input wire logic channel_a_output_o, // Output A
	input wire logic channel_b_output_o, // Output B
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [1:0] s_axi_bresp // Write response
);
	import gdl_pkg::*;
	logic [4:0] en_low;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// Count cycles with enable low, saturating
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			en_low <= 5'h00;
		else if (ctl_i.enable)
			en_low <= 5'h00;
		else if (en_low != 5'h1f)
			en_low <= en_low + 5'h01;
	end
	// ==========================================================
	// Properties
	sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
	sequence s_r_wait; s_axi_rvalid && !s_axi_rready; endsequence
	property p_in_lock;
		!supply_i.in_above_fall [*6] |-> !channel_a_output_o && !channel_b_output_o;
	endproperty
	property p_a_lock; !supply_i.a_above_fall [*5] |-> !channel_a_output_o; endproperty
	property p_b_lock; !supply_i.b_above_fall [*5] |-> !channel_b_output_o; endproperty
	property p_en_off;
		en_low >= 5'h14 |-> !channel_a_output_o && !channel_b_output_o;
	endproperty
	property p_ar_r; s_ar_taken |=> s_axi_rvalid; endproperty
	property p_r_hold; s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	property p_r_block; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_in_lock: assert property (p_in_lock)
		else $error("output high while input side locked");
	a_a_lock: assert property (p_a_lock)
		else $error("output A high while its supply is low");
	a_b_lock: assert property (p_b_lock)
		else $error("output B high while its supply is low");
	a_en_off: assert property (p_en_off)
		else $error("output high long after enable fell");
	a_ar_r: assert property (p_ar_r)
		else $error("read data not valid after address");
	a_r_hold: assert property (p_r_hold)
		else $error("read data changed while stalled");
	a_r_block: assert property (p_r_block)
		else $error("read data still valid after it was taken");
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped while stalled");
endmodule
bind gdl_driver gdl_driver_assertions chk_u (
	.clock_i(clock_i), .rst_i(rst_i), .supply_i(supply_i), .ctl_i(ctl_i),
	.channel_a_output_o(channel_a_output_o), .channel_b_output_o(channel_b_output_o),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp)
);

// File: verif/gdl_pwm_model.sv
// Controller model: toggles input A as a PWM source, enable held high.
// Assumes the bench clock; idles with A low while run_i is low.
`timescale 1ns/100ps
module gdl_pwm_model (
	input wire logic clock_i, // Bench clock
	input wire logic run_i, // Start toggling
	input wire logic [7:0] half_i, // Half period less one, in cycles
	output gdl_pkg::gdl_ctl_t ctl_o // Pins to the driver
);
	import gdl_pkg::*;
	logic [7:0] cnt;
	// ==========================================================
	// Flip input A each half period, B as its complement
	always_ff @(posedge clock_i) begin
		if (!run_i) begin
			cnt <= 8'h00;
			ctl_o <= 3'h3;
		end else if (cnt == half_i) begin
			cnt <= 8'h00;
			ctl_o <= {~ctl_o.channel_a_input, ctl_o.channel_a_input, 1'b1};
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

// File: verif/testbench.sv
// Testbench for the gate driver block: supplies, modes, dead time, registers.
// Assumes design, package and checker are compiled first.
`timescale 1ns/100ps
module testbench;
	import gdl_pkg::*;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	gdl_supply_t sup = 6'h3f;
	logic [2:0] tc = 3'h5;
	gdl_ctl_t mc;
	logic run = 1'b0;
	logic oa, ob, awr, wr, bv, arr, rv;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdat;
	logic [1:0] bres, rres;
	int n_mismatch = 0;
	int n_compared = 0;
	always #2.5 clock_i = ~clock_i;
	gdl_pwm_model pm_u (.clock_i(clock_i), .run_i(run), .half_i(8'hc8), .ctl_o(mc));
	gdl_driver #(.STARTUP_CYC(8)) dut_u (
		.clock_i(clock_i), .rst_i(rst_i), .supply_i(sup),
		.ctl_i(run ? mc : gdl_ctl_t'(tc)),
		.channel_a_output_o(oa), .channel_b_output_o(ob),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bres), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rr)
	);
	// ==========================================================
	// Shared helpers
	task cyc(input int n); repeat (n) @(posedge clock_i); endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task step(input gdl_supply_t s, input logic [2:0] c, input logic [1:0] e);
		@(posedge clock_i);
		sup <= s;
		tc <= c;
		cyc(40);
		chk(32'({oa, ob}), 32'(e));
	endtask
	task rg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge clock_i);
		awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
		while (!done) begin
			@(posedge clock_i);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
			if (bv) begin
				br <= 1'b0; done = 1'b1; chk(32'(bres), 32'(er));
			end
		end
	endtask
	task rg_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge clock_i);
		ara <= a; arv <= 1'b1; rr <= 1'b1;
		while (!done) begin
			@(posedge clock_i);
			if (arv && arr) arv <= 1'b0;
			if (rv) begin
				rr <= 1'b0; done = 1'b1; chk(rdat, ed); chk(32'(rres), 32'(er));
			end
		end
	endtask
	// ==========================================================
	// Scenarios
	task t_regs;
		rg_rd(8'h00, 32'h0, 2'h0);
		rg_rd(8'h04, 32'h4, 2'h0);
		rg_rd(8'h0c, 32'h0, 2'h2);
		rg_wr(8'h0c, 32'h1, 2'h2);
		rg_wr(8'h00, 32'h1, 2'h0);
		rg_rd(8'h00, 32'h1, 2'h0);
		rg_rd(8'h08, 32'h71, 2'h0);
	endtask
	task t_half;
		step(6'h3f, 3'h7, 2'h0);
		step(6'h3f, 3'h3, 2'h1);
		step(6'h3f, 3'h7, 2'h0);
		step(6'h3f, 3'h5, 2'h2);
	endtask
	task t_dual;
		rg_wr(8'h00, 32'h0, 2'h0);
		for (int i = 0; i < 4; i++) step(6'h3f, {2'(i), 1'b1}, 2'(i));
		rg_wr(8'h00, 32'h3, 2'h0);
		step(6'h3f, 3'h7, 2'h3);
	endtask
	task t_pwm;
		rg_wr(8'h00, 32'h2, 2'h0);
		step(6'h3f, 3'h5, 2'h2);
		step(6'h3f, 3'h1, 2'h1);
		step(6'h3f, 3'h0, 2'h0);
		step(6'h3f, 3'h1, 2'h1);
	endtask
	task t_dt;
		int g, lo, hi;
		logic [3:0] m [3];
		int d [3];
		int e [3];
		m = '{4'h6, 4'he, 4'h6};
		d = '{10, 2, 255};
		e = '{10, 4, 40};
		for (int i = 0; i < 3; i++) begin
			rg_wr(8'h00, 32'(m[i]), 2'h0);
			rg_wr(8'h04, 32'(d[i]), 2'h0);
			rg_rd(8'h04, 32'(d[i]), 2'h0);
			lo = 999; hi = 0; g = 0;
			@(posedge clock_i);
			run <= 1'b1;
			repeat (900) begin
				@(posedge clock_i);
				if (!oa && !ob) g++;
				else begin
					if (g > 0 && g < lo) lo = g;
					if (g > hi) hi = g;
					g = 0;
				end
			end
			run <= 1'b0;
			chk(32'(lo >= e[i] && hi >= e[i] && hi <= e[i] + 3), 32'h1);
		end
	endtask
	task t_lock;
		rg_wr(8'h00, 32'h0, 2'h0);
		step(6'h3f, 3'h7, 2'h3);
		step(6'h33, 3'h7, 2'h1);
		step(6'h37, 3'h7, 2'h1);
		step(6'h3f, 3'h7, 2'h3);
		step(6'h3c, 3'h7, 2'h2);
		step(6'h3f, 3'h7, 2'h3);
	endtask
	task t_in;
		int n;
		step(6'h0f, 3'h7, 2'h0);
		step(6'h0f, 3'h6, 2'h0);
		step(6'h0f, 3'h7, 2'h0);
		step(6'h1f, 3'h7, 2'h0);
		@(posedge clock_i);
		sup <= 6'h3f;
		for (n = 0; n < 1400 && {oa, ob} !== 2'h3; n++) @(posedge clock_i);
		chk(32'({oa, ob}), 32'h3);
	endtask
	task final_report;
		$display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		cyc(16);
		rst_i <= 1'b0;
		cyc(2);
		chk(32'({oa, ob}), 32'h0);
		step(6'h3f, 3'h5, 2'h2);
		$display("startup done");
		t_regs;
		$display("registers done");
		t_half;
		$display("half bridge done");
		t_dual;
		$display("dual done");
		t_pwm;
		$display("pwm and enable done");
		t_dt;
		$display("dead time done");
		t_lock;
		$display("channel lockout done");
		t_in;
		$display("input lockout done");
		final_report;
	end
	initial begin
		cyc(20000);
		n_mismatch++;
		final_report;
	end
endmodule
